// ---- design/lsac_top.sv ----
// Alignment control core: APB registers, mode sequencing, error capture.
// Assumes sysref_i is a one-cycle pulse with phase_err_i valid beside it.
module lsac_top (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sysref_i,
  input wire logic [3:0] phase_err_i,
  output logic clk_adjust_o,
  output logic align_logic_on_o,
  output logic [3:0] present_phase_error_o,
  output logic rotated_o,
  output logic tripped_o
);
  typedef struct packed {
    logic [1:0] tol;
    logic [7:0] ctrl;
    logic [3:0] last_err;
    logic last_under;
    logic last_over;
    logic [3:0] cur_err;
    logic rotated;
    logic tripped;
    lsac_pkg::lsac_state_t st;
    logic adj;
    logic [31:0] rdata;
  } lsac_top_state_t;

  lsac_top_state_t st_reg;
  lsac_top_state_t st_next;
  lsac_win_if win ();
  logic [2:0] strb_rise;
  logic arm_rise;
  logic clrstky_rise;
  logic clrlast_rise;
  logic on;
  logic [3:0] mode;
  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  logic evt;
  logic adjust_ok;
  logic do_adj;
  logic [31:0] rd_mux;

  lsac_window u_window (
    .win(win)
  );

  lsac_edge #(
    .W(lsac_pkg::CTRL_STRB_W)
  ) u_edge (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .level_i(st_reg.ctrl[6:4]),
    .rise_o(strb_rise)
  );

  assign win.err = phase_err_i;
  assign win.tol = st_reg.tol;
  // Strobes only act on a fresh rising edge of the stored bit
  assign arm_rise = strb_rise[lsac_pkg::CTRL_ARM_BIT - 4];
  assign clrstky_rise = strb_rise[lsac_pkg::CTRL_CLRSTKY_BIT - 4];
  assign clrlast_rise = strb_rise[lsac_pkg::CTRL_CLRLAST_BIT - 4];
  assign on = st_reg.ctrl[lsac_pkg::CTRL_EN_BIT];
  assign mode = st_reg.ctrl[3:0];

  // Zero wait state; read data caught in the setup cycle
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite & addr_ok;
  assign rd_setup = psel & ~penable;
  assign pslverr = psel & penable & ~addr_ok;

  always_comb begin
    addr_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    if (paddr == lsac_pkg::ADDR_TOL) begin
      rd_mux = {30'h0000_0000, st_reg.tol};
    end else if (paddr == lsac_pkg::ADDR_LAST_L) begin
      rd_mux = {28'h000_0000, st_reg.last_err};
    end else if (paddr == lsac_pkg::ADDR_LAST_H) begin
      rd_mux = {24'h00_0000, st_reg.last_under, st_reg.last_over,
                6'h00};
    end else if (paddr == lsac_pkg::ADDR_CTRL) begin
      rd_mux = {24'h00_0000, st_reg.ctrl};
    end else if (paddr == lsac_pkg::ADDR_STATUS) begin
      rd_mux = {29'h0000_0000, st_reg.rotated, 1'b0, st_reg.tripped};
    end else begin
      addr_ok = 1'b0;
    end
  end

  // Which SYSREF pulses may rotate the clocks
  always_comb begin
    evt = sysref_i & on & (st_reg.st != lsac_pkg::ST_OFF);
    adjust_ok = 1'b0;
    case (st_reg.st)
      lsac_pkg::ST_ARMED: begin
        adjust_ok = (mode == lsac_pkg::MODE_ONE_SHOT) |
                    (mode == lsac_pkg::MODE_ONE_MON) |
                    (mode == lsac_pkg::MODE_CONT);
      end
      // Monitor state still obeys a later switch to continuous
      lsac_pkg::ST_IDLE, lsac_pkg::ST_MON: begin
        adjust_ok = (mode == lsac_pkg::MODE_CONT);
      end
      default: begin
        adjust_ok = 1'b0;
      end
    endcase
    do_adj = evt & adjust_ok & (win.under | win.over);
  end

  always_comb begin
    st_next = st_reg;
    st_next.adj = 1'b0;
    if (rd_setup) begin
      st_next.rdata = rd_mux;
    end
    if (wr_en && paddr == lsac_pkg::ADDR_TOL) begin
      st_next.tol = pwdata[1:0];
    end
    if (wr_en && paddr == lsac_pkg::ADDR_CTRL) begin
      st_next.ctrl = pwdata[7:0];
    end
    // Clears first so a same-cycle set below wins
    if (clrstky_rise) begin
      st_next.rotated = 1'b0;
      st_next.tripped = 1'b0;
    end
    if (clrlast_rise) begin
      st_next.last_err = 4'h0;
      st_next.last_under = 1'b0;
      st_next.last_over = 1'b0;
    end
    case (st_reg.st)
      lsac_pkg::ST_OFF: begin
        if (on) begin
          st_next.st = lsac_pkg::ST_IDLE;
        end
      end
      lsac_pkg::ST_IDLE, lsac_pkg::ST_MON: begin
        if (arm_rise) begin
          st_next.st = lsac_pkg::ST_ARMED;
        end
      end
      lsac_pkg::ST_ARMED: begin
        if (evt) begin
          st_next.tripped = 1'b1;
          if (mode == lsac_pkg::MODE_ONE_MON) begin
            st_next.st = lsac_pkg::ST_MON;
          end else begin
            st_next.st = lsac_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        st_next.st = lsac_pkg::ST_OFF;
      end
    endcase
    if (evt) begin
      st_next.cur_err = phase_err_i;
    end
    if (do_adj) begin
      st_next.adj = 1'b1;
      st_next.rotated = 1'b1;
      st_next.last_err = phase_err_i;
      st_next.last_under = win.under;
      st_next.last_over = win.over;
      st_next.cur_err = 4'h0;
    end
    // Disabling drops a pending arm as well
    if (!on) begin
      st_next.st = lsac_pkg::ST_OFF;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
      st_reg.tol <= lsac_pkg::TOL_RESET[1:0];
      st_reg.ctrl <= lsac_pkg::CTRL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.rdata;
  assign clk_adjust_o = st_reg.adj;
  assign align_logic_on_o = on;
  assign present_phase_error_o = st_reg.cur_err;
  assign rotated_o = st_reg.rotated;
  assign tripped_o = st_reg.tripped;

  // Helper copies for the checks below
  logic past_under;
  logic past_over;
  logic past_adjok;
  always_ff @(posedge core_clk_i) begin
    past_under <= win.under;
    past_over <= win.over;
    past_adjok <= evt & adjust_ok;
  end

  property p_adj_cause;
    @(posedge core_clk_i) disable iff (!nrst_i)
      clk_adjust_o |-> $past(sysref_i) && $past(on);
  endproperty
  adj_needs_enable_a: assert property (p_adj_cause)
    else $error("Adjustment without enabled SYSREF");

  adj_outside_win_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      $rose(clk_adjust_o) || clk_adjust_o |-> past_under || past_over)
    else $error("Adjustment inside tolerance window");

  win_miss_adj_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      past_adjok && (past_under || past_over) |-> clk_adjust_o)
    else $error("Out of window error not adjusted");

  last_capture_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      clk_adjust_o |-> st_reg.last_err == $past(phase_err_i))
    else $error("Last error not captured");

  under_flag_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      clk_adjust_o |-> st_reg.last_under == past_under)
    else $error("Under flag wrong at adjustment");

  over_flag_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      clk_adjust_o |-> st_reg.last_over == past_over)
    else $error("Over flag wrong at adjustment");

  arm_takes_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      arm_rise && on
      && (st_reg.st == lsac_pkg::ST_IDLE || st_reg.st == lsac_pkg::ST_MON)
      |=> st_reg.st == lsac_pkg::ST_ARMED)
    else $error("Arm strobe not taken");

  sticky_clear_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      clrstky_rise && !evt |=> !rotated_o && !tripped_o)
    else $error("Sticky flags not cleared");

  last_clear_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      clrlast_rise && !do_adj
      |=> st_reg.last_err == 4'h0 && !st_reg.last_under
          && !st_reg.last_over)
    else $error("Last error not cleared");

  monitor_only_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      mode == lsac_pkg::MODE_MONITOR |=> !clk_adjust_o)
    else $error("Adjustment in monitor mode");

  one_mon_seq_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      st_reg.st == lsac_pkg::ST_ARMED && evt
      && mode == lsac_pkg::MODE_ONE_MON && on
      |=> st_reg.st == lsac_pkg::ST_MON ##1 !clk_adjust_o)
    else $error("One-shot then monitor sequence broken");

  rotate_sticky_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      rotated_o && !clrstky_rise |=> rotated_o)
    else $error("Rotated flag dropped");

  cur_zero_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      clk_adjust_o |-> present_phase_error_o == 4'h0 && rotated_o)
    else $error("Present error not zeroed");

  reset_state_a: assert property (
    @(posedge core_clk_i)
      !nrst_i |=> st_reg.ctrl == 8'h00 && st_reg.tol == 2'b00
                  && st_reg.last_err == 4'h0 && !clk_adjust_o)
    else $error("Reset values wrong");

  off_no_adj_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      !on |=> !clk_adjust_o && st_reg.st == lsac_pkg::ST_OFF)
    else $error("Activity while disabled");

  idle_one_shot_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      st_reg.st == lsac_pkg::ST_IDLE && mode == lsac_pkg::MODE_ONE_SHOT
      |=> !clk_adjust_o)
    else $error("Unarmed one-shot adjusted");

  cont_adjust_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      evt && mode == lsac_pkg::MODE_CONT && (win.under || win.over)
      |=> clk_adjust_o)
    else $error("Continuous mode missed an adjustment");

  tol_write_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      wr_en && paddr == lsac_pkg::ADDR_TOL
      |=> st_reg.tol == $past(pwdata[1:0]))
    else $error("Tolerance write lost");

  last_hold_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      !do_adj && !clrlast_rise |=> $stable(st_reg.last_err)
      && $stable(st_reg.last_under) && $stable(st_reg.last_over))
    else $error("Last error changed without cause");

  trip_armed_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      st_reg.st == lsac_pkg::ST_ARMED && evt |=> tripped_o)
    else $error("Armed SYSREF not flagged");

  rot_needs_adj_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      $rose(rotated_o) |-> clk_adjust_o)
    else $error("Rotated flag without adjustment");

  one_shot_c: cover property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      st_reg.st == lsac_pkg::ST_ARMED ##[1:50] clk_adjust_o);
  cont_twice_c: cover property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      mode == lsac_pkg::MODE_CONT && clk_adjust_o ##[1:50] clk_adjust_o);
  clear_after_adj_c: cover property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      clk_adjust_o ##[1:50] clrlast_rise);
  one_mon_c: cover property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      st_reg.st == lsac_pkg::ST_MON && evt);
  inside_win_c: cover property (
    @(posedge core_clk_i) disable iff (!nrst_i)
      evt && adjust_ok && !win.under && !win.over);
endmodule : lsac_top

// ---- design/lsac_pkg.sv ----
// Constants, modes and states of the multiframe clock alignment control.
// Assumes one 100 MHz clock and APB word access to byte offset 4 * index.
// Contract
// - Adjust only outside plus/minus tolerance window
// - Capture 4-bit signed error on adjustment
// - Last-error high bit 7: beyond lower bound
// - Last-error high bit 6: beyond upper bound
// - Control bit 7 enables alignment logic
// - Writing control bit 6 arms one-shot; code arms only on a 0-to-1 change of bit 6 while in idle or monitor state
// - Bit 5 rising clears rotated and tripped
// - Bit 4 rising clears last error, flags
// - Modes: one-shot, continuous, monitor only
// - Mode 1001: one-shot then monitor only
// - Sticky rotated flag set on clock rotation
// - Adjustment moves present error, zeroes it
package lsac_pkg;
  localparam int unsigned ERR_W = 4;
  localparam int unsigned TOL_W = 2;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam logic [9:0] IDX_TOL = 10'h034;
  localparam logic [9:0] IDX_LAST_L = 10'h038;
  localparam logic [9:0] IDX_LAST_H = 10'h039;
  localparam logic [9:0] IDX_CTRL = 10'h03a;
  localparam logic [9:0] IDX_STATUS = 10'h03b;
  localparam logic [11:0] ADDR_TOL = {IDX_TOL, 2'b00};
  localparam logic [11:0] ADDR_LAST_L = {IDX_LAST_L, 2'b00};
  localparam logic [11:0] ADDR_LAST_H = {IDX_LAST_H, 2'b00};
  localparam logic [11:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam int unsigned CTRL_EN_BIT = 7;
  localparam int unsigned CTRL_ARM_BIT = 6;
  localparam int unsigned CTRL_CLRSTKY_BIT = 5;
  localparam int unsigned CTRL_CLRLAST_BIT = 4;
  localparam int unsigned CTRL_STRB_LSB = 4;
  localparam int unsigned CTRL_STRB_W = 3;
  localparam int unsigned LASTH_UNDER_BIT = 7;
  localparam int unsigned LASTH_OVER_BIT = 6;
  localparam int unsigned STAT_ROT_BIT = 2;
  localparam int unsigned STAT_TRIP_BIT = 0;
  localparam logic [7:0] TOL_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  typedef enum logic [3:0] {
    MODE_NONE = 4'b0000,
    MODE_ONE_SHOT = 4'b0001,
    MODE_CONT = 4'b0010,
    MODE_MONITOR = 4'b1000,
    MODE_ONE_MON = 4'b1001
  } lsac_mode_t;
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_IDLE = 2'b01,
    ST_ARMED = 2'b10,
    ST_MON = 2'b11
  } lsac_state_t;
endpackage : lsac_pkg

// ---- design/lsac_win_if.sv ----
// Carrier between the control core and its window comparator.
// Assumes the comparator answers combinationally.
interface lsac_win_if;
  logic [3:0] err;
  logic [1:0] tol;
  logic under;
  logic over;
  modport cmp (input err, input tol, output under, output over);
  modport user (output err, output tol, input under, input over);
endinterface : lsac_win_if

// ---- design/lsac_window.sv ----
// Signed window compare of a phase error against plus/minus tolerance.
// Assumes a 4-bit two's complement error and unsigned tolerance.
module lsac_window (
  lsac_win_if.cmp win
);
  logic signed [4:0] err_s;
  logic signed [4:0] tol_s;
  always_comb begin
    err_s = $signed({win.err[3], win.err});
    tol_s = $signed({3'b000, win.tol});
    win.under = err_s < -tol_s;
    win.over = err_s > tol_s;
  end
endmodule : lsac_window

// ---- design/lsac_edge.sv ----
// Rising edge detectors for a group of software strobe bits.
// Assumes the strobes come from flops on the same clock.
module lsac_edge #(
  parameter int unsigned W = 3
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] level_i,
  output logic [W-1:0] rise_o
);
  typedef struct packed {
    logic [W-1:0] prev;
  } lsac_edge_state_t;
  lsac_edge_state_t st_reg;
  lsac_edge_state_t st_next;
  always_comb begin
    st_next = st_reg;
    st_next.prev = level_i;
  end
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  for (genvar i = 0; i < W; i++) begin : g_rise
    assign rise_o[i] = level_i[i] & ~st_reg.prev[i];
  end
endmodule : lsac_edge

// ---- tb/lsac_sysref_src.sv ----
// Far-side model: a SYSREF source giving one-cycle pulses with an error.
// Assumes the bench asks for a pulse by raising fire_i for one cycle.
module lsac_sysref_src (
  input wire logic core_clk_i,
  input wire logic fire_i,
  input wire logic [3:0] err_i,
  output logic sysref_o,
  output logic [3:0] phase_err_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sysref_o = 1'b0;
    phase_err_o = 4'h0;
  end
  // Error inverted each cycle outside the pulse, so the stale value shows again only every other cycle
  always @(posedge core_clk_i) begin
    sysref_o <= fire_i;
    phase_err_o <= fire_i ? err_i : ~phase_err_o;
  end
endmodule : lsac_sysref_src

// ---- tb/testbench.sv ----
// Self-checking bench: APB register traffic and SYSREF events.
// Assumes a zero-wait APB slave and the SYSREF source model.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] ctl;
    logic [1:0] tol;
    logic [3:0] err;
    logic adj;
    logic trip;
  } lsac_row_t;
  localparam int NR = 11;
  lsac_row_t rows [NR] = '{{8'hc1, 2'h1, 4'h3, 1'b1, 1'b1},
    {8'hc1, 2'h1, 4'he, 1'b1, 1'b1}, {8'hc1, 2'h1, 4'h1, 1'b0, 1'b1},
    {8'hc1, 2'h3, 4'hd, 1'b0, 1'b1}, {8'hc1, 2'h3, 4'hc, 1'b1, 1'b1},
    {8'h81, 2'h0, 4'h1, 1'b0, 1'b0}, {8'h82, 2'h0, 4'h7, 1'b1, 1'b0},
    {8'h82, 2'h2, 4'h8, 1'b1, 1'b0}, {8'h88, 2'h0, 4'h5, 1'b0, 1'b0},
    {8'hc9, 2'h0, 4'h2, 1'b1, 1'b1}, {8'h41, 2'h0, 4'h5, 1'b0, 1'b0}};
  logic core_clk_i, nrst_i, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic sysref, fire, adj, se, clk_adjust_o, on_o, rot_o, trip_o;
  logic [3:0] perr, ferr, pres_o;
  lsac_row_t r;
  int error_cnt = 0;
  int checked = 0;
  lsac_top i_lsac_top (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sysref_i(sysref), .phase_err_i(perr), .clk_adjust_o(clk_adjust_o),
    .align_logic_on_o(on_o), .present_phase_error_o(pres_o),
    .rotated_o(rot_o), .tripped_o(trip_o));
  lsac_sysref_src i_lsac_sysref_src (.core_clk_i(core_clk_i),
    .fire_i(fire), .err_i(ferr), .sysref_o(sysref), .phase_err_o(perr));
  task close_out;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      close_out();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk_i);
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  task sref(input logic [3:0] e);
    fire <= 1'b1;
    ferr <= e;
    @(posedge core_clk_i);
    fire <= 1'b0;
    @(posedge core_clk_i);
    #1;
    adj = clk_adjust_o;
    @(posedge core_clk_i);
    #1;
    chk(clk_adjust_o, 1'b0);
    @(posedge core_clk_i);
  endtask : sref
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    nrst_i = 1'b0;
    {psel, penable, pwrite, fire} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ferr = 4'h0;
    repeat (6) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(posedge core_clk_i);
    for (int i = 0; i < NR; i++) begin
      r = rows[i];
      wr(lsac_pkg::ADDR_TOL, {30'h0, r.tol});
      wr(lsac_pkg::ADDR_CTRL, {24'h0, (r.ctl & 8'hbf) | 8'h30});
      wr(lsac_pkg::ADDR_CTRL, {24'h0, r.ctl});
      rdchk(lsac_pkg::ADDR_CTRL, {24'h0, r.ctl});
      chk(on_o, r.ctl[7]);
      sref(r.err);
      chk(adj, r.adj);
      rdchk(lsac_pkg::ADDR_LAST_L, {28'h0, r.adj ? r.err : 4'h0});
      rdchk(lsac_pkg::ADDR_LAST_H,
            {24'h0, r.adj & r.err[3], r.adj & ~r.err[3], 6'h0});
      rdchk(lsac_pkg::ADDR_STATUS, {29'h0, r.adj, 1'b0, r.trip});
      if (r.ctl[7]) chk(pres_o, r.adj ? 4'h0 : r.err);
    end
    // Sticky clear leaves the captured error alone
    wr(lsac_pkg::ADDR_CTRL, 32'h82);
    sref(4'h5);
    wr(lsac_pkg::ADDR_CTRL, 32'ha2);
    rdchk(lsac_pkg::ADDR_STATUS, 32'h0);
    chk({rot_o, trip_o}, 2'b00);
    rdchk(lsac_pkg::ADDR_LAST_L, 32'h5);
    wr(lsac_pkg::ADDR_CTRL, 32'h92);
    rdchk(lsac_pkg::ADDR_LAST_L, 32'h0);
    wr(lsac_pkg::ADDR_TOL, 32'hffffffff);
    rdchk(lsac_pkg::ADDR_TOL, 32'h3);
    wr(lsac_pkg::ADDR_LAST_H, 32'hff);
    rdchk(lsac_pkg::ADDR_LAST_H, 32'h0);
    wr(12'h000, 32'hff);
    chk(se, 1'b1);
    rdchk(12'h000, 32'h0);
    chk(se, 1'b1);
    // One-shot then monitor: second SYSREF must not adjust
    wr(lsac_pkg::ADDR_CTRL, 32'ha9);
    wr(lsac_pkg::ADDR_CTRL, 32'hc9);
    sref(4'h5);
    chk(adj, 1'b1);
    sref(4'h5);
    chk(adj, 1'b0);
    // Second reset in mid-run
    nrst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(posedge core_clk_i);
    rdchk(lsac_pkg::ADDR_TOL, 32'h0);
    rdchk(lsac_pkg::ADDR_CTRL, 32'h0);
    rdchk(lsac_pkg::ADDR_LAST_L, 32'h0);
    rdchk(lsac_pkg::ADDR_LAST_H, 32'h0);
    chk(on_o, 1'b0);
    close_out();
  end
endmodule : testbench
